//--- hw/ptc_top.sv
// Three-channel interval timer behind four host byte locations, with the pacer chain.
// Assumes host strobes, user clock and gate are synchronous to CLK; one strobe per cycle.
`timescale 1ns/1ps
`default_nettype none
module ptc_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // host byte port
    input  wire logic [1:0]  HOST_ADDR,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_RD,
    input  wire logic [7:0]  HOST_WDATA,
    output logic      [7:0]  HOST_RDATA,
    // user counter on the connector
    input  wire logic        USR_CLK,
    input  wire logic        USR_GATE,
    output logic             USR_OUT,
    // A/D trigger selection and pacer
    input  wire logic        PACER_SEL,
    input  wire logic        EXT_TRIG_SEL,
    output logic             PACER_OUT,
    output logic             AD_START
);

    ////////////////////////////////////////////////////////////////////////////
    // register side state, one entry per counter

    ptc_pkg::ptc_ctrl_t ctrl_q  [3];
    ptc_pkg::ptc_ctrl_t ctrl_d  [3];
    logic [15:0]        cr_q    [3];
    logic [15:0]        cr_d    [3];
    logic [15:0]        latch_q [3];
    logic [15:0]        latch_d [3];
    logic [7:0]         lsb_q   [3];
    logic [7:0]         lsb_d   [3];
    logic [15:0]        cnt_w   [3];
    logic [2:0]         wr_hi_q, wr_hi_d, rd_hi_q, rd_hi_d;
    logic [2:0]         latched_q, latched_d;
    logic [2:0]         load_q, load_d, cfg_q, cfg_d;
    logic [7:0]         rdata_q, rdata_d;
    ptc_pkg::ptc_ctrl_t cw;
    logic [15:0]        src;

    assign cw = ptc_pkg::ptc_ctrl_t'(HOST_WDATA);
    assign src = latched_q[HOST_ADDR] ? latch_q[HOST_ADDR] : cnt_w[HOST_ADDR];

    always_comb begin
        ctrl_d    = ctrl_q;
        cr_d      = cr_q;
        latch_d   = latch_q;
        lsb_d     = lsb_q;
        wr_hi_d   = wr_hi_q;
        rd_hi_d   = rd_hi_q;
        latched_d = latched_q;
        load_d    = 3'h0;
        cfg_d     = 3'h0;
        rdata_d   = rdata_q;
        if (HOST_WR && HOST_ADDR == ptc_pkg::OFS_CTRL) begin
            if (cw.sel != ptc_pkg::SEL_ILLEGAL) begin
                if (cw.rw == ptc_pkg::RW_LATCH) begin
                    // a second latch before the read is ignored
                    if (!latched_q[cw.sel]) begin
                        latch_d[cw.sel]   = cnt_w[cw.sel];
                        latched_d[cw.sel] = 1'b1;
                    end
                end else begin
                    ctrl_d[cw.sel] = cw;
                    if (cw.mode[1]) begin
                        ctrl_d[cw.sel].mode[2] = 1'b0;
                    end
                    wr_hi_d[cw.sel]   = 1'b0;
                    rd_hi_d[cw.sel]   = 1'b0;
                    latched_d[cw.sel] = 1'b0;
                    cfg_d[cw.sel]     = 1'b1;
                end
            end
        end else if (HOST_WR) begin
            // count writes follow the programmed access style
            case (ctrl_q[HOST_ADDR].rw)
                ptc_pkg::RW_LSB: begin
                    cr_d[HOST_ADDR]   = {8'h00, HOST_WDATA};
                    load_d[HOST_ADDR] = 1'b1;
                end
                ptc_pkg::RW_MSB: begin
                    cr_d[HOST_ADDR]   = {HOST_WDATA, 8'h00};
                    load_d[HOST_ADDR] = 1'b1;
                end
                ptc_pkg::RW_BOTH: begin
                    if (!wr_hi_q[HOST_ADDR]) begin
                        lsb_d[HOST_ADDR]   = HOST_WDATA;
                        wr_hi_d[HOST_ADDR] = 1'b1;
                    end else begin
                        cr_d[HOST_ADDR]    = {HOST_WDATA, lsb_q[HOST_ADDR]};
                        wr_hi_d[HOST_ADDR] = 1'b0;
                        load_d[HOST_ADDR]  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (HOST_RD && HOST_ADDR == ptc_pkg::OFS_CTRL) begin
            rdata_d = ptc_pkg::RDATA_RST;
        end else if (HOST_RD) begin
            case (ctrl_q[HOST_ADDR].rw)
                ptc_pkg::RW_LSB: begin
                    rdata_d              = src[7:0];
                    latched_d[HOST_ADDR] = 1'b0;
                end
                ptc_pkg::RW_MSB: begin
                    rdata_d              = src[15:8];
                    latched_d[HOST_ADDR] = 1'b0;
                end
                default: begin
                    rdata_d            = rd_hi_q[HOST_ADDR] ? src[15:8] : src[7:0];
                    rd_hi_d[HOST_ADDR] = ~rd_hi_q[HOST_ADDR];
                    if (rd_hi_q[HOST_ADDR]) begin
                        latched_d[HOST_ADDR] = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_q[i]  <= ptc_pkg::ptc_ctrl_t'(ptc_pkg::CTRL_RST);
                cr_q[i]    <= ptc_pkg::COUNT_RST;
                latch_q[i] <= ptc_pkg::COUNT_RST;
                lsb_q[i]   <= ptc_pkg::RDATA_RST;
            end
            wr_hi_q   <= 3'h0;
            rd_hi_q   <= 3'h0;
            latched_q <= 3'h0;
            load_q    <= 3'h0;
            cfg_q     <= 3'h0;
            rdata_q   <= ptc_pkg::RDATA_RST;
        end else if (CE) begin
            ctrl_q    <= ctrl_d;
            cr_q      <= cr_d;
            latch_q   <= latch_d;
            lsb_q     <= lsb_d;
            wr_hi_q   <= wr_hi_d;
            rd_hi_q   <= rd_hi_d;
            latched_q <= latched_d;
            load_q    <= load_d;
            cfg_q     <= cfg_d;
            rdata_q   <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count sources and pacer chain

    logic [3:0] div_q, div_d;
    logic       usr_clk_q, usr_clk_d;
    logic [2:0] out_w, tick;
    logic [2:0] gate_w;
    logic       o1_q, o2_q;
    logic       usr_out_q, pacer_q, start_q, start_d;

    // user clock is sampled, so it must stay below half of CLK; 5 MHz fits
    assign tick[0]   = USR_CLK & ~usr_clk_q;
    assign tick[1]   = (div_q == ptc_pkg::PACER_LAST);
    assign tick[2]   = out_w[1] & ~o1_q;
    assign gate_w    = {1'b1, 1'b1, USR_GATE};
    assign usr_clk_d = USR_CLK;
    assign div_d     = tick[1] ? 4'h0 : div_q + 4'h1;
    assign start_d   = out_w[2] & ~o2_q & PACER_SEL & ~EXT_TRIG_SEL;

    for (genvar g = 0; g < 3; g++) begin : g_cnt
        ptc_counter ptc_counter_inst (
            .clk    (CLK),
            .rst    (RST),
            .ce     (CE),
            .tick   (tick[g]),
            .gate   (gate_w[g]),
            .cfg_wr (cfg_q[g]),
            .mode   (ctrl_q[g].mode),
            .bcd    (ctrl_q[g].bcd),
            .load   (load_q[g]),
            .cr     (cr_q[g]),
            .cnt    (cnt_w[g]),
            .out    (out_w[g])
        );
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_q     <= 4'h0;
            usr_clk_q <= 1'b0;
            o1_q      <= 1'b0;
            o2_q      <= 1'b0;
            usr_out_q <= 1'b0;
            pacer_q   <= 1'b0;
            start_q   <= 1'b0;
        end else if (CE) begin
            div_q     <= div_d;
            usr_clk_q <= usr_clk_d;
            o1_q      <= out_w[1];
            o2_q      <= out_w[2];
            usr_out_q <= out_w[0];
            pacer_q   <= out_w[2];
            start_q   <= start_d;
        end
    end

    assign HOST_RDATA = rdata_q;
    assign USR_OUT    = usr_out_q;
    assign PACER_OUT  = pacer_q;
    assign AD_START   = start_q;

endmodule : ptc_top
`default_nettype wire

//--- hw/ptc_pkg.sv
// Shared constants and types of the three-channel pacer timer/counter.
// Assumes one 20 MHz clock and a byte-wide host port of four locations.
package ptc_pkg;

    // host locations
    localparam logic [1:0] OFS_CNT0    = 2'h0;
    localparam logic [1:0] OFS_CNT1    = 2'h1;
    localparam logic [1:0] OFS_CNT2    = 2'h2;
    localparam logic [1:0] OFS_CTRL    = 2'h3;

    // control byte field codes
    localparam logic [1:0] SEL_ILLEGAL = 2'h3;
    localparam logic [1:0] RW_LATCH    = 2'h0;
    localparam logic [1:0] RW_LSB      = 2'h1;
    localparam logic [1:0] RW_MSB      = 2'h2;
    localparam logic [1:0] RW_BOTH     = 2'h3;

    localparam logic [2:0] MODE_TC     = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE   = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SWSTB  = 3'h4;
    localparam logic [2:0] MODE_HWSTB  = 3'h5;

    // reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] COUNT_RST  = 16'h0000;
    localparam logic [7:0]  RDATA_RST  = 8'h00;

    // timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned PACER_SRC_HZ = 2_000_000;
    localparam int unsigned PACER_DIV    = CLK_HZ / PACER_SRC_HZ;
    localparam logic [3:0]  PACER_LAST   = 4'(PACER_DIV - 1);

    // control byte, bit 7 first
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] rw;
        logic [2:0] mode;
        logic       bcd;
    } ptc_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } ptc_state_t;

endpackage : ptc_pkg

//--- hw/ptc_counter.sv
// One 16-bit counting engine with six modes.
// Assumes tick is a one-cycle count pulse and gate is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ptc_counter (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce,
    // count source
    input  wire logic            tick,
    input  wire logic            gate,
    // configuration from the register side
    input  wire logic            cfg_wr,
    input  wire logic [2:0]      mode,
    input  wire logic            bcd,
    input  wire logic            load,
    input  wire logic [15:0]     cr,
    // state
    output logic      [15:0]     cnt,
    output logic                 out
);

    ptc_pkg::ptc_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d, nxt1, nxt2;
    logic        out_q, out_d, gate_q, trig_q, trig_d;

    // decimal digits wrap 0 -> 9 with borrow, so 0000 rolls to 9999
    function automatic logic [15:0] dec1(input logic [15:0] v, input logic b10);
        logic [15:0] r;
        logic        brw;
        r   = v - 16'h0001;
        brw = 1'b1;
        if (b10) begin
            r = v;
            for (int k = 0; k < 4; k++) begin
                if (brw) begin
                    if (r[k*4 +: 4] == 4'h0) begin
                        r[k*4 +: 4] = 4'h9;
                    end else begin
                        r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : dec1

    assign nxt1 = dec1(cnt_q, bcd);
    assign nxt2 = dec1(nxt1, bcd);
    assign cnt  = cnt_q;
    assign out  = out_q;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        out_d  = out_q;
        trig_d = trig_q | (gate & ~gate_q);
        if (cfg_wr) begin
            // output parks until a count arrives
            st_d   = ptc_pkg::ST_IDLE;
            out_d  = (mode != ptc_pkg::MODE_TC);
            trig_d = 1'b0;
        end else begin
            if (load && (st_q != ptc_pkg::ST_RUN || mode == ptc_pkg::MODE_TC || mode == ptc_pkg::MODE_SWSTB)) begin
                st_d = ptc_pkg::ST_ARMED;
                if (mode == ptc_pkg::MODE_TC) begin
                    out_d = 1'b0;
                end
            end
            case (st_q)
                ptc_pkg::ST_IDLE: begin
                end
                ptc_pkg::ST_ARMED: begin
                    if (tick && ((mode != ptc_pkg::MODE_ONESHOT && mode != ptc_pkg::MODE_HWSTB) || trig_d)) begin
                        cnt_d  = (mode == ptc_pkg::MODE_SQUARE) ? {cr[15:1], 1'b0} : cr;
                        st_d   = ptc_pkg::ST_RUN;
                        trig_d = 1'b0;
                        out_d  = (mode != ptc_pkg::MODE_ONESHOT && mode != ptc_pkg::MODE_TC);
                    end
                end
                ptc_pkg::ST_RUN: begin
                    if (tick) begin
                        case (mode)
                            ptc_pkg::MODE_TC: begin
                                if (gate) begin
                                    cnt_d = nxt1;
                                    if (nxt1 == 16'h0000) out_d = 1'b1;
                                end
                            end
                            ptc_pkg::MODE_ONESHOT: begin
                                // a new gate edge retriggers the pulse
                                if (trig_q) begin
                                    cnt_d  = cr;
                                    out_d  = 1'b0;
                                    // a gate edge in this very cycle survives the clear
                                    trig_d = gate & ~gate_q;
                                end else if (!out_q) begin
                                    cnt_d = nxt1;
                                    if (nxt1 == 16'h0000) out_d = 1'b1;
                                end
                            end
                            ptc_pkg::MODE_RATE: begin
                                if (!gate) begin
                                    out_d = 1'b1;
                                end else if (trig_q || cnt_q == 16'h0001) begin
                                    cnt_d  = cr;
                                    out_d  = 1'b1;
                                    trig_d = gate & ~gate_q;
                                end else begin
                                    cnt_d = nxt1;
                                    if (nxt1 == 16'h0001) out_d = 1'b0;
                                end
                            end
                            ptc_pkg::MODE_SQUARE: begin
                                // odd reloads lose one count; the half periods stay equal
                                if (!gate) begin
                                    out_d = 1'b1;
                                end else if (trig_q || cnt_q == 16'h0002) begin
                                    cnt_d  = {cr[15:1], 1'b0};
                                    out_d  = trig_q | ~out_q;
                                    trig_d = gate & ~gate_q;
                                end else begin
                                    cnt_d = nxt2;
                                end
                            end
                            ptc_pkg::MODE_SWSTB, ptc_pkg::MODE_HWSTB: begin
                                if (!out_q) begin
                                    out_d = 1'b1;
                                    st_d  = (mode == ptc_pkg::MODE_HWSTB) ? ptc_pkg::ST_ARMED : ptc_pkg::ST_IDLE;
                                end else if (gate || mode == ptc_pkg::MODE_HWSTB) begin
                                    cnt_d = nxt1;
                                    if (nxt1 == 16'h0000) out_d = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: st_d = ptc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= ptc_pkg::ST_IDLE;
            cnt_q  <= ptc_pkg::COUNT_RST;
            out_q  <= 1'b0;
            gate_q <= 1'b0;
            trig_q <= 1'b0;
        end else if (ce) begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            out_q  <= out_d;
            gate_q <= gate;
            trig_q <= trig_d;
        end
    end

endmodule : ptc_counter
`default_nettype wire

//--- dv/ptc_chk.sv
// Port assertions for the three-channel pacer timer/counter.
// Assumes it is bound to ptc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ptc_chk (
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       CE,
    // host port
    input wire logic [1:0] HOST_ADDR,
    input wire logic       HOST_WR,
    input wire logic       HOST_RD,
    input wire logic [7:0] HOST_WDATA,
    input wire logic [7:0] HOST_RDATA,
    // counters and trigger
    input wire logic       USR_CLK,
    input wire logic       USR_GATE,
    input wire logic       USR_OUT,
    input wire logic       PACER_SEL,
    input wire logic       EXT_TRIG_SEL,
    input wire logic       PACER_OUT,
    input wire logic       AD_START
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////
    logic [7:0] gap_d, gap_q;
    logic       pout_d, pout_q;
    logic       ctl0_wr;
    // cycles since the last pacer rise, saturating
    always_comb begin
        pout_d = PACER_OUT;
        gap_d  = (PACER_OUT && !pout_q) ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            gap_q  <= 8'hFF;
            pout_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            pout_q <= pout_d;
        end
    end
    assign ctl0_wr = CE && HOST_WR && HOST_ADDR == 2'h3 && HOST_WDATA[7:6] == 2'h0 && HOST_WDATA[5:4] != 2'h0;
    ////////////////////////////////////////////////////////////////
    a_start_on_rise: assert property (($rose(PACER_OUT) && PACER_SEL && !EXT_TRIG_SEL && $stable(PACER_SEL)
        && $stable(EXT_TRIG_SEL)) |-> ##[0:2] AD_START) else $error("no start after pacer rise");
    a_start_blocked: assert property (((!PACER_SEL || EXT_TRIG_SEL) [*3]) |-> !AD_START)
        else $error("start while pacer not chosen");
    a_start_single: assert property (AD_START |=> !AD_START) else $error("start pulse too long");
    a_ctrl_reads_zero: assert property ((CE && HOST_RD && HOST_ADDR == 2'h3) |=> HOST_RDATA == 8'h00)
        else $error("control location read not zero");
    a_rdata_holds: assert property (!(CE && HOST_RD) |=> $stable(HOST_RDATA))
        else $error("read byte changed without read");
    a_freeze_all: assert property (!CE |=> $stable(USR_OUT) && $stable(PACER_OUT) && $stable(AD_START))
        else $error("output moved while frozen");
    a_mode0_low: assert property ((ctl0_wr && HOST_WDATA[3:1] == 3'h0) |-> ##4 !USR_OUT)
        else $error("mode 0 output not low after control");
    a_other_high: assert property ((ctl0_wr && HOST_WDATA[3:1] != 3'h0) |-> ##4 USR_OUT)
        else $error("output not high after control");
    a_pacer_gap: assert property ($rose(PACER_OUT) |-> gap_q >= 8'h27)
        else $error("pacer faster than source over four");
    c_start: cover property (AD_START);
    c_bcd_ctrl: cover property (ctl0_wr && HOST_WDATA[0]);
    c_freeze: cover property (!CE ##1 CE);
endmodule : ptc_chk
bind ptc_top ptc_chk ptc_chk_inst (.CLK(CLK), .RST(RST), .CE(CE), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .USR_CLK(USR_CLK), .USR_GATE(USR_GATE),
    .USR_OUT(USR_OUT), .PACER_SEL(PACER_SEL), .EXT_TRIG_SEL(EXT_TRIG_SEL), .PACER_OUT(PACER_OUT),
    .AD_START(AD_START));
`default_nettype wire

//--- dv/ptc_host_model.sv
// Host processor model: byte writes and reads on the four locations.
// Assumes callers enter its task at a falling CLK edge.
`timescale 1ns/1ps
`default_nettype none
module ptc_host_model (
    // clock
    input  wire logic       CLK,
    // host byte port
    output logic      [1:0] HOST_ADDR,
    output logic            HOST_WR,
    output logic            HOST_RD,
    output logic      [7:0] HOST_WDATA
);
    initial begin
        HOST_ADDR  = 2'h0;
        HOST_WR    = 1'b0;
        HOST_RD    = 1'b0;
        HOST_WDATA = 8'h00;
    end
    // one strobe cycle then one idle cycle, so no strobe is set and cleared in one step
    task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d);
        HOST_ADDR  = a;
        HOST_WDATA = d;
        HOST_WR    = wr;
        HOST_RD    = !wr;
        @(negedge CLK);
        HOST_WR    = 1'b0;
        HOST_RD    = 1'b0;
        HOST_WDATA = ~d; // idle data is junk, never the last byte
        @(negedge CLK);
    endtask : access
endmodule : ptc_host_model
`default_nettype wire

//--- dv/pacer_timer_counter_bench.sv
// Self-checking bench for the pacer timer/counter with a host model.
// Assumes the checker is bound to ptc_top; inputs change at falling CLK.
`timescale 1ns/1ps
`default_nettype none
module pacer_timer_counter_bench;
    logic        CLK = 1'b0, RST = 1'b1, CE = 1'b1, HOST_WR, HOST_RD;
    logic        USR_CLK = 1'b0, USR_GATE = 1'b1, USR_OUT, PACER_SEL = 1'b1, EXT_TRIG_SEL = 1'b0;
    logic        PACER_OUT, AD_START, rd_hit = 1'b0;
    logic [1:0]  HOST_ADDR;
    logic [7:0]  HOST_WDATA, HOST_RDATA, exp_q[$];
    logic [31:0] seed = 32'h7631, r;
    logic [15:0] n;
    logic [7:0]  t_ctl[3] = '{8'h31, 8'h31, 8'h30};
    logic [15:0] t_cnt[3] = '{16'h0050, 16'h0002, 16'h0001};
    logic [15:0] t_exp[3] = '{16'h0047, 16'h9999, 16'hFFFF};
    logic [7:0]  p1[2] = '{8'h02, 8'h05}, p2[2] = '{8'h02, 8'h03};
    int          t_tick[3] = '{4, 4, 3};
    int          err_count = 0, samples_checked = 0, cnt, k, i;
    always #25 CLK = ~CLK;
    ptc_top ptc_top_inst (.CLK(CLK), .RST(RST), .CE(CE), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR),
        .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .USR_CLK(USR_CLK),
        .USR_GATE(USR_GATE), .USR_OUT(USR_OUT), .PACER_SEL(PACER_SEL), .EXT_TRIG_SEL(EXT_TRIG_SEL),
        .PACER_OUT(PACER_OUT), .AD_START(AD_START));
    ptc_host_model ptc_host_model_inst (.CLK(CLK), .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR),
        .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        ptc_host_model_inst.access(1'b1, a, d);
    endtask : wr
    // the expected byte is noted first; the monitor compares it one cycle on
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        ptc_host_model_inst.access(1'b0, a, e);
    endtask : rd
    // user clock well under the 10 MHz sampling limit
    task automatic uclk(input int m);
        repeat (m) begin
            USR_CLK = 1'b1;
            repeat (2) @(negedge CLK);
            USR_CLK = 1'b0;
            repeat (2) @(negedge CLK);
        end
    endtask : uclk
    task automatic wait_start(output int w);
        w = 0;
        do begin
            @(negedge CLK);
            w++;
        end while (AD_START !== 1'b1 && w < 2000);
        if (w >= 2000) begin
            chk("start timeout", 16'h0001, 16'h0000);
            tally_and_finish();
        end
    endtask : wait_start
    ////////////////////////////////////////////////////////////////
    always @(posedge CLK) rd_hit <= HOST_RD && CE;
    always @(negedge CLK) begin
        if (rd_hit) begin
            if (exp_q.size() == 0) chk("stray read", 16'h0001, 16'h0000);
            else chk("read byte", {8'h00, HOST_RDATA}, {8'h00, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (100000) @(negedge CLK);
        chk("run timeout", 16'h0001, 16'h0000);
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge CLK);
        RST = 1'b0;
        r = $random(seed);
        n = 16'h0100 + {4'h0, r[11:0]};
        k = int'(r[14:12]) + 1;
        wr(2'h3, 8'h30);
        wr(2'h0, 8'hAA);
        wr(2'h3, 8'h30);
        wr(2'h0, n[7:0]);
        wr(2'h0, n[15:8]);
        uclk(1);
        chk("out after load", {15'h0000, USR_OUT}, 16'h0000);
        // edges while frozen must be lost
        CE = 1'b0;
        uclk(2);
        CE = 1'b1;
        // mode 0 holds its count while the gate is low
        USR_GATE = 1'b0;
        uclk(2);
        USR_GATE = 1'b1;
        uclk(k);
        n = n - 16'(k);
        wr(2'h3, 8'h00);
        uclk(2);
        rd(2'h0, n[7:0]);
        rd(2'h0, n[15:8]);
        n = n - 16'h0002;
        rd(2'h0, n[7:0]);
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h03);
        wr(2'h0, 8'h00);
        uclk(3);
        repeat (4) @(negedge CLK);
        chk("out before end", {15'h0000, USR_OUT}, 16'h0000);
        uclk(1);
        repeat (4) @(negedge CLK);
        chk("out at end", {15'h0000, USR_OUT}, 16'h0001);
        for (i = 0; i < 3; i++) begin
            wr(2'h3, t_ctl[i]);
            wr(2'h0, t_cnt[i][7:0]);
            wr(2'h0, t_cnt[i][15:8]);
            uclk(t_tick[i]);
            rd(2'h0, t_exp[i][7:0]);
            rd(2'h0, t_exp[i][15:8]);
        end
        wr(2'h3, 8'h1C);
        wr(2'h0, 8'h34);
        uclk(1);
        rd(2'h0, 8'h34);
        rd(2'h0, 8'h34);
        wr(2'h3, 8'h20);
        wr(2'h0, 8'h12);
        uclk(1);
        wr(2'h3, 8'hF0);
        rd(2'h0, 8'h12);
        rd(2'h3, 8'h00);
        for (i = 0; i < 2; i++) begin
            RST = 1'b1;
            repeat (2) @(negedge CLK);
            RST = 1'b0;
            wr(2'h3, 8'h74);
            wr(2'h3, 8'hB4);
            wr(2'h2, p2[i]);
            wr(2'h2, 8'h00);
            wr(2'h1, p1[i]);
            wr(2'h1, 8'h00);
            wait_start(cnt);
            wait_start(cnt);
            wait_start(cnt);
            chk("pacer level", {15'h0000, PACER_OUT}, 16'h0001);
            chk("pacer interval", 16'(cnt), 16'(ptc_pkg::PACER_DIV * p1[i] * p2[i]));
        end
        for (i = 0; i < 2; i++) begin
            PACER_SEL = (i == 1);
            EXT_TRIG_SEL = (i == 1);
            cnt = 0;
            repeat (200) begin
                @(negedge CLK);
                if (AD_START === 1'b1) cnt++;
            end
            chk("blocked starts", 16'(cnt), 16'h0000);
        end
        tally_and_finish();
    end
endmodule : pacer_timer_counter_bench
`default_nettype wire
